// file: hdl/status_vbi_pkg.sv
// Purpose: constants for the decoder status and vbi readout register group
// Assumes: 8-bit register addresses, 8-bit read data
// Notes:   offsets are byte sub-addresses of the host port
package status_vbi_pkg;
   // ==========================================================
   // register offsets
   localparam logic [7:0] OFS_IRQ_B_PIN_ACTIVE    = 8'h87;
   localparam logic [7:0] OFS_LOCK_SIGNAL_STATUS  = 8'h88;
   localparam logic [7:0] OFS_SIGNAL_STATUS_TWO   = 8'h89;
   localparam logic [7:0] OFS_FRONT_GAIN_READOUT  = 8'h8a;
   localparam logic [7:0] OFS_SUBCARRIER_PHASE    = 8'h8b;
   localparam logic [7:0] OFS_DETECTED_STANDARD   = 8'h8c;
   localparam logic [7:0] OFS_CAPTION_F1_B1       = 8'h90;
   localparam logic [7:0] OFS_CAPTION_F1_B2       = 8'h91;
   localparam logic [7:0] OFS_CAPTION_F2_B1       = 8'h92;
   localparam logic [7:0] OFS_CAPTION_F2_B2       = 8'h93;
   localparam logic [7:0] OFS_WIDESCREEN_F1_B1    = 8'h94;
   localparam logic [7:0] OFS_WIDESCREEN_F1_B2    = 8'h95;
   localparam logic [7:0] OFS_WIDESCREEN_F1_B3    = 8'h96;
   localparam logic [7:0] OFS_WIDESCREEN_F2_B1    = 8'h97;
   localparam logic [7:0] OFS_WIDESCREEN_F2_B2    = 8'h98;
   localparam logic [7:0] OFS_WIDESCREEN_F2_B3    = 8'h99;
   // ==========================================================
   // status register one field positions
   localparam int BIT_PEAK_WHITE   = 7;
   localparam int BIT_LINE_ALT     = 6;
   localparam int BIT_FIELD_50HZ   = 5;
   localparam int BIT_LOST_LOCK    = 4;
   localparam int BIT_COLOUR_LOCK  = 3;
   localparam int BIT_VSYNC_LOCK   = 2;
   localparam int BIT_HSYNC_LOCK   = 1;
   localparam int BIT_SOURCE_TYPE  = 0;
   // status register two field positions
   localparam int BIT_WEAK_SIGNAL  = 6;
   localparam int BIT_PHASE_TOGGLE = 5;
   localparam int BIT_ODD_FIELD    = 4;
   localparam int BIT_GAIN_FROZEN  = 3;
   // status register five field positions
   localparam int BIT_AUTOSWITCH   = 7;
   localparam int LSB_STANDARD     = 1;
   localparam int BIT_SAMPLE_RATE  = 0;
   // ==========================================================
   // detected standard codes in bits 3:1
   localparam logic [2:0] STD_NTSC_M    = 3'h0;
   localparam logic [2:0] STD_PAL_BGHIN = 3'h1;
   localparam logic [2:0] STD_PAL_M     = 3'h2;
   localparam logic [2:0] STD_PAL_N     = 3'h3;
   localparam logic [2:0] STD_NTSC_443  = 3'h4;
   localparam logic [2:0] STD_SECAM     = 3'h5;
   // values after reset
   localparam logic [7:0] RESET_BYTE    = 8'h00;
   localparam logic       RESET_BIT     = 1'b0;
   localparam logic [19:0] RESET_WORD   = 20'h0_0000;
endpackage

// file: hdl/decoder_status_vbi_readout.sv
// Purpose: read side status and vbi capture registers of one decoder channel
// Assumes: decoder core signals on clk_sys; host read strobe one cycle wide
// Notes:   only host access path is rd/wr strobes with 8-bit sub-address
`timescale 1ns/100ps
module decoder_status_vbi_readout
   import status_vbi_pkg::*;
(
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   // host register port
   input  wire logic        reg_rd,
   input  wire logic        reg_wr,
   input  wire logic [7:0]  reg_addr,
   input  wire logic [7:0]  reg_wdata,
   output logic      [7:0]  reg_rdata,
   output logic             reg_rvalid,
   // decoder core status levels
   input  wire logic        irq_b_pin_level,
   input  wire logic        peak_white,
   input  wire logic        line_alternating,
   input  wire logic        field_rate_50hz,
   input  wire logic        lock_lost_event,
   input  wire logic        colour_locked,
   input  wire logic        vsync_locked,
   input  wire logic        hsync_locked,
   input  wire logic        source_type_flag,
   input  wire logic        weak_signal,
   input  wire logic        phase_alternation_toggle,
   input  wire logic        odd_field,
   input  wire logic        gain_frozen,
   input  wire logic [9:0]  front_gain,
   input  wire logic [7:0]  subcarrier_to_sync_phase,
   input  wire logic        autoswitch_running,
   input  wire logic [2:0]  detected_standard,
   input  wire logic        sample_rate_flag,
   // vbi capture inputs
   input  wire logic        caption_valid,
   input  wire logic        caption_field2,
   input  wire logic [15:0] caption_word,
   input  wire logic        widescreen_valid,
   input  wire logic        widescreen_field2,
   input  wire logic        widescreen_50hz,
   input  wire logic [19:0] widescreen_word
);

   // ==========================================================
   // capture storage
   logic [7:0]  caption_mem [4];
   logic [19:0] widescreen_mem [2];
   logic        wide_is_50 [2];
   logic        lost_lock;
   logic        next_lost_lock;
   logic [7:0]  next_rdata;
   logic        rd_status_one;
   logic        next_reg_rvalid;
   logic [7:0]  next_reg_rdata;

   assign rd_status_one = reg_rd && (reg_addr == OFS_LOCK_SIGNAL_STATUS);

   // sticky lost lock: a loss in the clearing read cycle wins over the clear
   always_comb
   begin
      next_lost_lock = lost_lock;
      if (rd_status_one)
         next_lost_lock = 1'b0;
      if (lock_lost_event)
         next_lost_lock = 1'b1;
   end

   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         lost_lock <= RESET_BIT;
      else
         lost_lock <= next_lost_lock;
   end

   // caption bytes and wide-screen words, one field slot per capture
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_field
         logic [7:0]  next_cap_b1;
         logic [7:0]  next_cap_b2;
         logic [19:0] next_wide;
         logic        next_w50;
         always_comb
         begin
            next_cap_b1 = caption_mem[2*gi];
            next_cap_b2 = caption_mem[2*gi+1];
            next_wide   = widescreen_mem[gi];
            next_w50    = wide_is_50[gi];
            if (caption_valid && (caption_field2 == 1'(gi)))
            begin
               next_cap_b1 = caption_word[7:0];
               next_cap_b2 = caption_word[15:8];
            end
            if (widescreen_valid && (widescreen_field2 == 1'(gi)))
            begin
               next_wide = widescreen_word;
               next_w50  = widescreen_50hz;
            end
         end
         always_ff @(posedge clk_sys or negedge resetn)
         begin
            if (!resetn)
            begin
               caption_mem[2*gi]   <= RESET_BYTE;
               caption_mem[2*gi+1] <= RESET_BYTE;
               widescreen_mem[gi]  <= RESET_WORD;
               wide_is_50[gi]      <= RESET_BIT;
            end
            else
            begin
               caption_mem[2*gi]   <= next_cap_b1;
               caption_mem[2*gi+1] <= next_cap_b2;
               widescreen_mem[gi]  <= next_wide;
               wide_is_50[gi]      <= next_w50;
            end
         end
      end
   endgenerate

   // wide-screen byte layout depends on the rate the word was taken at
   function automatic logic [7:0] wide_byte(input logic [19:0] w,
                                            input logic is50,
                                            input int idx);
      logic [7:0] b;
      b = 8'h00;
      if (is50)
      begin
         // 50 Hz: 14 bits, third byte unused
         if (idx == 0)
            b = w[7:0];
         else if (idx == 1)
            b = {2'b00, w[13:8]};
      end
      else
      begin
         // 60 Hz: aspect 1:0, header 5:2 / copy 13:6 / crc 19:14
         if (idx == 0)
            b = {2'b00, w[5:0]};
         else if (idx == 1)
            b = w[13:6];
         else
            b = {2'b00, w[19:14]};
      end
      return b;
   endfunction

   // read mux; writes are ignored, reserved bits are zero
   always_comb
   begin
      next_rdata = 8'h00;
      case (reg_addr)
         OFS_IRQ_B_PIN_ACTIVE:
            next_rdata = {7'h00, irq_b_pin_level};
         OFS_LOCK_SIGNAL_STATUS:
         begin
            next_rdata[BIT_PEAK_WHITE]  = peak_white;
            next_rdata[BIT_LINE_ALT]    = line_alternating;
            next_rdata[BIT_FIELD_50HZ]  = field_rate_50hz;
            next_rdata[BIT_LOST_LOCK]   = lost_lock;
            next_rdata[BIT_COLOUR_LOCK] = colour_locked;
            next_rdata[BIT_VSYNC_LOCK]  = vsync_locked;
            next_rdata[BIT_HSYNC_LOCK]  = hsync_locked;
            next_rdata[BIT_SOURCE_TYPE] = source_type_flag;
         end
         OFS_SIGNAL_STATUS_TWO:
         begin
            next_rdata[BIT_WEAK_SIGNAL]  = weak_signal;
            next_rdata[BIT_PHASE_TOGGLE] = phase_alternation_toggle;
            next_rdata[BIT_ODD_FIELD]    = odd_field;
            next_rdata[BIT_GAIN_FROZEN]  = gain_frozen;
         end
         OFS_FRONT_GAIN_READOUT:
            next_rdata = front_gain[9:2];
         OFS_SUBCARRIER_PHASE:
            next_rdata = subcarrier_to_sync_phase;
         OFS_DETECTED_STANDARD:
         begin
            next_rdata[BIT_AUTOSWITCH] = autoswitch_running;
            next_rdata[LSB_STANDARD +: 3] = detected_standard;
            next_rdata[BIT_SAMPLE_RATE] = sample_rate_flag;
         end
         OFS_CAPTION_F1_B1:    next_rdata = caption_mem[0];
         OFS_CAPTION_F1_B2:    next_rdata = caption_mem[1];
         OFS_CAPTION_F2_B1:    next_rdata = caption_mem[2];
         OFS_CAPTION_F2_B2:    next_rdata = caption_mem[3];
         OFS_WIDESCREEN_F1_B1: next_rdata = wide_byte(widescreen_mem[0], wide_is_50[0], 0);
         OFS_WIDESCREEN_F1_B2: next_rdata = wide_byte(widescreen_mem[0], wide_is_50[0], 1);
         OFS_WIDESCREEN_F1_B3: next_rdata = wide_byte(widescreen_mem[0], wide_is_50[0], 2);
         OFS_WIDESCREEN_F2_B1: next_rdata = wide_byte(widescreen_mem[1], wide_is_50[1], 0);
         OFS_WIDESCREEN_F2_B2: next_rdata = wide_byte(widescreen_mem[1], wide_is_50[1], 1);
         OFS_WIDESCREEN_F2_B3: next_rdata = wide_byte(widescreen_mem[1], wide_is_50[1], 2);
         default:              next_rdata = 8'h00;
      endcase
   end

   // answer held until the next read strobe so a slow host can still pick it up
   always_comb
   begin
      next_reg_rvalid = reg_rd;
      next_reg_rdata  = reg_rdata;
      if (reg_rd)
         next_reg_rdata = next_rdata;
   end

   // data registered one cycle after the read strobe
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         reg_rdata  <= RESET_BYTE;
         reg_rvalid <= RESET_BIT;
      end
      else
      begin
         reg_rvalid <= next_reg_rvalid;
         reg_rdata  <= next_reg_rdata;
      end
   end

   // ==========================================================
   // assertions: interrupt mirror and status one
   AST_IRQ_MIRROR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_IRQ_B_PIN_ACTIVE) |=>
         reg_rdata == {7'h00, $past(irq_b_pin_level)})
      else $error("interrupt active readback wrong");
   AST_LOST_SET: assert property (@(posedge clk_sys) disable iff (!resetn)
      lock_lost_event |=> lost_lock)
      else $error("lost lock not set");
   AST_LOST_CLEAR: assert property (@(posedge clk_sys) disable iff (!resetn)
      (rd_status_one && !lock_lost_event) |=> !lost_lock)
      else $error("lost lock not cleared by read");
   AST_LOST_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (lost_lock && !rd_status_one) |=> lost_lock)
      else $error("lost lock dropped without read");
   AST_LOST_SHOWN: assert property (@(posedge clk_sys) disable iff (!resetn)
      rd_status_one |=> reg_rdata[BIT_LOST_LOCK] == $past(lost_lock))
      else $error("lost lock readback wrong");
   AST_STATUS_ONE: assert property (@(posedge clk_sys) disable iff (!resetn)
      rd_status_one |=> reg_rdata[BIT_PEAK_WHITE] == $past(peak_white)
         && reg_rdata[BIT_SOURCE_TYPE] == $past(source_type_flag))
      else $error("status one readback wrong");
   AST_FIELD_RATE: assert property (@(posedge clk_sys) disable iff (!resetn)
      rd_status_one |=> reg_rdata[BIT_LINE_ALT] == $past(line_alternating)
         && reg_rdata[BIT_FIELD_50HZ] == $past(field_rate_50hz))
      else $error("line alternation or field rate readback wrong");
   AST_LOCKS: assert property (@(posedge clk_sys) disable iff (!resetn)
      rd_status_one |=> reg_rdata[BIT_COLOUR_LOCK] == $past(colour_locked)
         && reg_rdata[BIT_VSYNC_LOCK] == $past(vsync_locked)
         && reg_rdata[BIT_HSYNC_LOCK] == $past(hsync_locked))
      else $error("lock status readback wrong");

   // status two, gain, phase and standard
   AST_STATUS_TWO_RSVD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_SIGNAL_STATUS_TWO) |=>
         reg_rdata[7] == 1'b0 && reg_rdata[2:0] == 3'h0)
      else $error("status two reserved bits not zero");
   AST_STATUS_TWO: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_SIGNAL_STATUS_TWO) |=>
         reg_rdata[BIT_WEAK_SIGNAL] == $past(weak_signal)
         && reg_rdata[BIT_PHASE_TOGGLE] == $past(phase_alternation_toggle)
         && reg_rdata[BIT_ODD_FIELD] == $past(odd_field))
      else $error("status two readback wrong");
   AST_FROZEN: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_SIGNAL_STATUS_TWO) |=>
         reg_rdata[BIT_GAIN_FROZEN] == $past(gain_frozen))
      else $error("frozen loop flag readback wrong");
   AST_GAIN: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_FRONT_GAIN_READOUT) |=>
         reg_rdata == $past(front_gain[9:2]))
      else $error("gain readback wrong");
   AST_PHASE: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_SUBCARRIER_PHASE) |=>
         reg_rdata == $past(subcarrier_to_sync_phase))
      else $error("subcarrier phase readback wrong");
   AST_STANDARD: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_DETECTED_STANDARD) |=>
         reg_rdata[3:1] == $past(detected_standard)
         && reg_rdata[6:4] == 3'h0)
      else $error("standard readback wrong");
   AST_AUTOSWITCH: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_DETECTED_STANDARD) |=>
         reg_rdata[BIT_AUTOSWITCH] == $past(autoswitch_running)
         && reg_rdata[BIT_SAMPLE_RATE] == $past(sample_rate_flag))
      else $error("autoswitch or sample rate readback wrong");

   // caption and wide-screen capture and layout
   AST_CAPTION_F1: assert property (@(posedge clk_sys) disable iff (!resetn)
      (caption_valid && !caption_field2) |=>
         {caption_mem[1], caption_mem[0]} == $past(caption_word))
      else $error("field one caption not captured");
   AST_CAPTION_F2: assert property (@(posedge clk_sys) disable iff (!resetn)
      (caption_valid && caption_field2) |=>
         {caption_mem[3], caption_mem[2]} == $past(caption_word))
      else $error("field two caption not captured");
   AST_CAPTION_READ: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_CAPTION_F2_B2) |=>
         reg_rdata == $past(caption_mem[3]))
      else $error("field two caption byte two readback wrong");
   AST_WSS_TAKE: assert property (@(posedge clk_sys) disable iff (!resetn)
      (widescreen_valid && !widescreen_field2) |=>
         widescreen_mem[0] == $past(widescreen_word)
         && wide_is_50[0] == $past(widescreen_50hz))
      else $error("field one wide-screen word not captured");
   AST_WSS_60: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_WIDESCREEN_F1_B2 && !wide_is_50[0]) |=>
         reg_rdata == $past(widescreen_mem[0][13:6]))
      else $error("60 Hz copy control byte wrong");
   AST_WSS_60_CRC: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_WIDESCREEN_F1_B3 && !wide_is_50[0]) |=>
         reg_rdata == {2'b00, $past(widescreen_mem[0][19:14])})
      else $error("60 Hz crc byte wrong");
   AST_WSS_50: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_WIDESCREEN_F2_B2 && wide_is_50[1]) |=>
         reg_rdata == {2'b00, $past(widescreen_mem[1][13:8])})
      else $error("50 Hz second byte wrong");
   AST_WSS_50_NONE: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && reg_addr == OFS_WIDESCREEN_F2_B3 && wide_is_50[1]) |=> reg_rdata == 8'h00)
      else $error("50 Hz third byte not zero");

   // host port behaviour
   AST_UNMAPPED: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_rd && (reg_addr < OFS_IRQ_B_PIN_ACTIVE || reg_addr > OFS_WIDESCREEN_F2_B3))
         |=> reg_rdata == 8'h00)
      else $error("unmapped address not zero");
   AST_WRITE_IGNORED: assert property (@(posedge clk_sys) disable iff (!resetn)
      (reg_wr && !reg_rd) |=> $stable(reg_rdata) && !reg_rvalid)
      else $error("host write disturbed the read port");
   AST_RDATA_HOLD: assert property (@(posedge clk_sys) disable iff (!resetn)
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data moved without a read");
   AST_RVALID: assert property (@(posedge clk_sys) disable iff (!resetn)
      reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd)))
      else $error("read valid timing wrong");

   // main scenarios worth seeing at least once
   COV_LOST_READ: cover property (@(posedge clk_sys) disable iff (!resetn)
      lost_lock ##1 rd_status_one ##1 !lost_lock);
   COV_SET_WINS: cover property (@(posedge clk_sys) disable iff (!resetn)
      (rd_status_one && lock_lost_event) ##1 lost_lock);
   COV_WSS_50: cover property (@(posedge clk_sys) disable iff (!resetn)
      widescreen_valid && widescreen_50hz);
   COV_WSS_60: cover property (@(posedge clk_sys) disable iff (!resetn)
      widescreen_valid && !widescreen_50hz);
   COV_CAPTION_F2: cover property (@(posedge clk_sys) disable iff (!resetn)
      caption_valid && caption_field2);
endmodule

// file: test/host_poller.sv
// Purpose: host processor model polling the status and vbi register group
// Assumes: one-cycle read strobe, answer flagged by reg_rvalid next cycle
// Notes:   writes are issued only to show they leave the registers alone
`timescale 1ns/100ps
module host_poller
(
   // clock
   input  wire logic       clk_sys,
   // register port
   output logic            reg_rd,
   output logic            reg_wr,
   output logic [7:0]      reg_addr,
   output logic [7:0]      reg_wdata,
   input  wire logic [7:0] reg_rdata,
   input  wire logic       reg_rvalid
);
   int timeouts;
   // ==========================================================
   // idle port after time zero
   initial
   begin
      reg_rd    = 1'b0;
      reg_wr    = 1'b0;
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      timeouts  = 0;
   end
   // ==========================================================
   // poll one register; address inverted after use so stale values never pass
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      int n;
      begin
         @(posedge clk_sys);
         reg_rd   <= 1'b1;
         reg_addr <= a;
         @(posedge clk_sys);
         reg_rd   <= 1'b0;
         reg_addr <= ~a;
         n = 0;
         #1;
         while (reg_rvalid !== 1'b1 && n < 4)
         begin
            @(posedge clk_sys);
            #1;
            n++;
         end
         if (reg_rvalid !== 1'b1)
            timeouts++;
         d = reg_rdata;
      end
   endtask
   // write strobe; every register here is read only
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      begin
         @(posedge clk_sys);
         reg_wr    <= 1'b1;
         reg_addr  <= a;
         reg_wdata <= d;
         @(posedge clk_sys);
         reg_wr    <= 1'b0;
         reg_addr  <= ~a;
         reg_wdata <= ~d;
      end
   endtask
endmodule

// file: test/test_decoder_status_vbi_readout.sv
// Purpose: self-checking bench for the status and vbi readout registers
// Assumes: host_poller speaks the strobe port; core levels driven here
// Notes:   level inputs packed in lv so one walking loop covers all but lock_lost_event
`timescale 1ns/100ps
module test_decoder_status_vbi_readout;
   import status_vbi_pkg::*;
   logic        clk_sys, resetn, reg_rd, reg_wr, reg_rvalid;
   logic [7:0]  reg_addr, reg_wdata, reg_rdata, phase;
   logic [14:0] lv, nv;
   logic [9:0]  gain;
   logic [2:0]  std;
   logic        cap_v, cap_f2, wss_v, wss_f2, wss_50;
   logic [15:0] cap_w;
   logic [19:0] wss_w;
   int          bad_count, checks;
   localparam logic [19:0] W60 = 20'hb_6d2e;
   localparam logic [19:0] W50 = 20'h5_2d96;
   localparam logic [7:0]  REGS [18] = '{8'h87, 8'h88, 8'h89, 8'h8a, 8'h8b, 8'h8c, 8'h8d,
      8'h90, 8'h91, 8'h92, 8'h93, 8'h94, 8'h95, 8'h96, 8'h97, 8'h98, 8'h99, 8'h9a};
   // ==========================================================
   // design and host model
   decoder_status_vbi_readout DUT (.clk_sys, .resetn, .reg_rd, .reg_wr, .reg_addr,
      .reg_wdata, .reg_rdata, .reg_rvalid, .irq_b_pin_level(lv[12]), .peak_white(lv[7]),
      .line_alternating(lv[6]), .field_rate_50hz(lv[5]), .lock_lost_event(lv[4]),
      .colour_locked(lv[3]), .vsync_locked(lv[2]), .hsync_locked(lv[1]),
      .source_type_flag(lv[0]), .weak_signal(lv[11]), .phase_alternation_toggle(lv[10]),
      .odd_field(lv[9]), .gain_frozen(lv[8]), .front_gain(gain),
      .subcarrier_to_sync_phase(phase), .autoswitch_running(lv[13]),
      .detected_standard(std), .sample_rate_flag(lv[14]), .caption_valid(cap_v),
      .caption_field2(cap_f2), .caption_word(cap_w), .widescreen_valid(wss_v),
      .widescreen_field2(wss_f2), .widescreen_50hz(wss_50), .widescreen_word(wss_w));
   host_poller HOST (.clk_sys, .reg_rd, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
      .reg_rvalid);
   // 125 MHz clock
   initial
   begin
      clk_sys = 1'b0;
      forever #4 clk_sys = ~clk_sys;
   end
   // ==========================================================
   // closing report, the single place the run ends
   task automatic give_verdict;
      begin
         $display("checks=%0d bad_count=%0d", checks, bad_count);
         if (bad_count == 0 && checks > 0)
            $display("Result: passed");
         else
            $display("Result: failed");
         $finish;
      end
   endtask
   // read one register and compare; a lost answer ends the run
   task automatic rc(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      begin
         HOST.rd(a, d);
         checks++;
         if (HOST.timeouts != 0)
         begin
            bad_count++;
            $display("[ERR] t=%0t addr=%h no answer got=%h exp=%h", $time, a, d, exp);
            give_verdict();
         end
         else if (d !== exp)
         begin
            bad_count++;
            $display("[ERR] t=%0t addr=%h got=%h exp=%h", $time, a, d, exp);
         end
      end
   endtask
   // one-cycle capture pulses from the slicer side
   task automatic cap(input logic f2, input logic [15:0] w);
      begin
         @(posedge clk_sys);
         {cap_v, cap_f2, cap_w} <= {1'b1, f2, w};
         @(posedge clk_sys);
         {cap_v, cap_w} <= {1'b0, ~w};
      end
   endtask
   task automatic wss(input logic f2, input logic r50, input logic [19:0] w);
      begin
         @(posedge clk_sys);
         {wss_v, wss_f2, wss_50, wss_w} <= {1'b1, f2, r50, w};
         @(posedge clk_sys);
         {wss_v, wss_w} <= {1'b0, ~w};
      end
   endtask
   // ==========================================================
   // main sequence
   initial
   begin
      {lv, gain, phase, std, cap_v, cap_f2, cap_w} = '0;
      {wss_v, wss_f2, wss_50, wss_w, resetn, bad_count, checks} = '0;
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      // quiet inputs: mapped and unmapped places all read zero
      foreach (REGS[i]) rc(REGS[i], 8'h00);
      // walk each level input except lock_lost_event; other registers must not pick it up
      for (int i = 0; i < 15; i++)
      begin
         if (i == 4)
            continue;
         nv = 15'(1) << i;
         @(posedge clk_sys);
         lv <= nv;
         rc(8'h87, {7'h00, nv[12]});
         rc(8'h88, nv[7:0]);
         rc(8'h89, {1'b0, nv[11:8], 3'b000});
         rc(8'h8c, {nv[13], 6'h00, nv[14]});
      end
      // sticky lost lock: a loss during the clearing read keeps it set
      @(posedge clk_sys);
      lv <= 15'h0010;
      rc(8'h88, 8'h10);
      @(posedge clk_sys);
      lv <= '0;
      rc(8'h88, 8'h10);
      rc(8'h88, 8'h00);
      // gain upper bits and phase codes ff and 01
      @(posedge clk_sys);
      {gain, phase} <= {10'h2d7, 8'hff};
      rc(8'h8a, 8'hb5);
      rc(8'h8b, 8'hff);
      @(posedge clk_sys);
      {gain, phase} <= {10'h003, 8'h01};
      rc(8'h8a, 8'h00);
      rc(8'h8b, 8'h01);
      // every standard code under autoswitch at studio rate
      for (int s = 0; s < 6; s++)
      begin
         @(posedge clk_sys);
         {std, lv} <= {3'(s), 15'h6000};
         rc(8'h8c, {1'b1, 3'b000, 3'(s), 1'b1});
      end
      // captions per field, second capture must not touch the first
      cap(1'b0, 16'h5a3c);
      cap(1'b1, 16'hc3a5);
      foreach (REGS[i])
         if (i >= 7 && i <= 10)
            rc(REGS[i], (i == 7) ? 8'h3c : (i == 8) ? 8'h5a : (i == 9) ? 8'ha5 : 8'hc3);
      // wide-screen: field 1 at 60 Hz layout, field 2 at 50 Hz layout
      wss(1'b0, 1'b0, W60);
      wss(1'b1, 1'b1, W50);
      rc(8'h94, {2'b00, W60[5:0]});
      rc(8'h95, W60[13:6]);
      rc(8'h96, {2'b00, W60[19:14]});
      rc(8'h97, W50[7:0]);
      rc(8'h98, {2'b00, W50[13:8]});
      rc(8'h99, 8'h00);
      // host writes leave read-only contents alone
      HOST.wr(8'h90, 8'hff);
      HOST.wr(8'h88, 8'hff);
      rc(8'h90, 8'h3c);
      rc(8'h88, 8'h00);
      // mid-run reset empties captures and the sticky flag
      @(posedge clk_sys);
      lv <= 15'h0010;
      @(posedge clk_sys);
      {lv, resetn} <= {15'h0000, 1'b0};
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rc(8'h88, 8'h00);
      rc(8'h90, 8'h00);
      rc(8'h97, 8'h00);
      give_verdict();
   end
endmodule
